// File: hdl/scm_clock_mode_control.sv
// System clock and low-power mode control: clock mode register, idle keep bit,
// halt/wake sequencing and oscillator ready tracking.
// Assumes a CPU-side register port with read data one cycle later, and
// oscillator cycle ticks and strap levels synchronous to clock.
//
// Function
// - Divider codes 0,1 select substitute clock
// - Codes 2..7 give high clock /64../2
// - Fast wake-up runs substitute clock after wake; code does so only with the high crystal strap
// - Low ready flag low in deep sleep
// - Low ready after 128 or 2 cycles
// - High ready cleared at power-on, set when stable
// - Code sees high ready set after power-on
// - High ready low in sleep, clock-off idle
// - High ready after 512 or 16 cycles
// - Idle select high: halt enters idle
// - Idle with keep: CPU stops, clock runs
// - Idle without keep: CPU and clock stop
// - Idle select low: halt enters sleep
// - High select picks undivided high clock
// - Leaving high clock switches high oscillator off
// - Control register keep bit sets idle clock
//
// Decided for this implementation: strobed register access and the address map.

`timescale 1ns/100ps
`default_nettype none

module scm_clock_mode_control
  import scm_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   srst,
  // Register port
  input  wire scm_pkg::scm_bus_req_t  bus_req,
  output var  logic [7:0]             rdata,
  // CPU events
  input  wire logic                   halt,
  input  wire logic                   wake,
  // Oscillator straps and ticks
  input  wire scm_pkg::scm_osc_cfg_t  osc_cfg,
  input  wire logic                   sub_in_sleep,
  input  wire logic                   high_tick,
  input  wire logic                   low_tick,
  // Clock steering and mode
  output var  scm_pkg::scm_clk_out_t  clk_out,
  output var  scm_pkg::scm_mode_t     mode
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]   clock_divider_select;
    logic         fast_wakeup_enable;
    logic         idle_select;
    logic         high_speed_select;
    logic         idle_sysclk_keep;
    logic         sub_lost;
    scm_mode_t    mode;
    logic [7:0]   rdata;
    scm_clk_out_t clk;
  } scm_st_t;

  localparam scm_st_t ST_RST = '{
    clock_divider_select : SCM_RST_MODE[SCM_B_DIV_LO +: 3],
    fast_wakeup_enable   : SCM_RST_MODE[SCM_B_FAST],
    idle_select          : SCM_RST_MODE[SCM_B_IDLE],
    high_speed_select    : SCM_RST_MODE[SCM_B_HSEL],
    idle_sysclk_keep     : SCM_RST_CTRL[SCM_B_KEEP],
    sub_lost             : 1'b0,
    mode                 : SCM_WAKE,
    rdata                : 8'h00,
    clk                  : '0
  };

  scm_st_t cur;
  scm_st_t next_st;

  logic high_speed_ready_flag;
  logic low_speed_ready_flag;
  logic high_run;
  logic low_run;
  logic wants_high;
  logic fast_ok;

  // True when the configured system clock comes from the high oscillator
  function automatic logic uses_high(input logic hsel, input logic [2:0] div);
    uses_high = hsel || (div > SCM_DIV_SUB_MAX);
  endfunction

  // log2 of the divide ratio of the high clock
  function automatic logic [2:0] div_shift(input logic hsel, input logic [2:0] div);
    logic [3:0] diff;
    diff = SCM_DIV_TOP - {1'b0, div};
    if (hsel || !(div > SCM_DIV_SUB_MAX))
    begin
      div_shift = 3'h0;
    end
    else
    begin
      div_shift = diff[2:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Oscillator enables and ready flags
  // ----------------------------------------------------------------
  always_comb
  begin
    wants_high = uses_high(cur.high_speed_select, cur.clock_divider_select);
    // High oscillator runs only while the system clock needs it; moving to the
    // substitute clock stops it to save power
    high_run   = wants_high && ((cur.mode == SCM_RUN) || (cur.mode == SCM_IDLE_ON)
                 || (cur.mode == SCM_WAKE));
    low_run    = (cur.mode != SCM_SLEEP_DEEP);
    // Temporary substitute clock after wake; after deep sleep only once it has settled again
    fast_ok    = (cur.mode == SCM_WAKE) && cur.fast_wakeup_enable && osc_cfg.high_crystal
                 && wants_high && !cur.sub_lost && low_speed_ready_flag;
  end

  scm_osc_ready #(
    .CNT_W (SCM_CNT_W)
  ) u_high_ready (
    .clock  (clock),
    .srst   (srst),
    .run    (high_run),
    .tick   (high_tick),
    .target (osc_cfg.high_crystal ? SCM_HXT_CYC : SCM_HIGH_SPEED_RC_CYC),
    .ready  (high_speed_ready_flag)
  );

  scm_osc_ready #(
    .CNT_W (SCM_CNT_W)
  ) u_low_ready (
    .clock  (clock),
    .srst   (srst),
    .run    (low_run),
    .tick   (low_tick),
    .target (osc_cfg.low_crystal ? SCM_LXT_CYC : SCM_LOW_SPEED_RC_CYC),
    .ready  (low_speed_ready_flag)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st       = cur;
    next_st.rdata = 8'h00;

    // Register writes; ready flag positions are not stored
    if (bus_req.wr)
    begin
      if (bus_req.addr == SCM_IDX_MODE)
      begin
        next_st.clock_divider_select = bus_req.wdata[SCM_B_DIV_LO +: 3];
        next_st.fast_wakeup_enable   = bus_req.wdata[SCM_B_FAST];
        next_st.idle_select          = bus_req.wdata[SCM_B_IDLE];
        next_st.high_speed_select    = bus_req.wdata[SCM_B_HSEL];
      end
      else if (bus_req.addr == SCM_IDX_CTRL)
      begin
        next_st.idle_sysclk_keep     = bus_req.wdata[SCM_B_KEEP];
      end
    end

    // Register reads; unmapped addresses read zero
    if (bus_req.rd)
    begin
      if (bus_req.addr == SCM_IDX_MODE)
      begin
        next_st.rdata[SCM_B_DIV_LO +: 3] = cur.clock_divider_select;
        next_st.rdata[SCM_B_FAST]        = cur.fast_wakeup_enable;
        next_st.rdata[SCM_B_LRDY]        = low_speed_ready_flag;
        next_st.rdata[SCM_B_HRDY]        = high_speed_ready_flag;
        next_st.rdata[SCM_B_IDLE]        = cur.idle_select;
        next_st.rdata[SCM_B_HSEL]        = cur.high_speed_select;
      end
      else if (bus_req.addr == SCM_IDX_CTRL)
      begin
        next_st.rdata[SCM_B_KEEP]        = cur.idle_sysclk_keep;
      end
    end

    // Mode sequencing
    case (cur.mode)
      SCM_RUN:
      begin
        if (halt)
        begin
          if (cur.idle_select)
          begin
            next_st.mode = cur.idle_sysclk_keep ? SCM_IDLE_ON : SCM_IDLE_OFF;
          end
          else
          begin
            next_st.mode = sub_in_sleep ? SCM_SLEEP_SUB : SCM_SLEEP_DEEP;
          end
        end
      end
      SCM_IDLE_ON:
      begin
        // System clock kept running, so no settling wait
        if (wake)
        begin
          next_st.mode = SCM_RUN;
        end
      end
      SCM_IDLE_OFF, SCM_SLEEP_SUB:
      begin
        if (wake)
        begin
          next_st.mode = SCM_WAKE;
        end
      end
      SCM_SLEEP_DEEP:
      begin
        if (wake)
        begin
          next_st.mode     = SCM_WAKE;
          next_st.sub_lost = 1'b1;
        end
      end
      SCM_WAKE:
      begin
        // Power-on also starts here, so code first runs on a settled clock
        if (low_speed_ready_flag)
        begin
          next_st.sub_lost = 1'b0;
        end
        if (wants_high ? high_speed_ready_flag : low_speed_ready_flag)
        begin
          next_st.mode = SCM_RUN;
        end
      end
      default:
      begin
        next_st.mode = SCM_RUN;
      end
    endcase

    // Clock steering outputs
    next_st.clk.src_sub     = !wants_high || !high_speed_ready_flag;
    next_st.clk.div_log2    = div_shift(cur.high_speed_select, cur.clock_divider_select);
    next_st.clk.cpu_run     = (cur.mode == SCM_RUN) || fast_ok;
    next_st.clk.sysclk_run  = (cur.mode == SCM_RUN) || (cur.mode == SCM_IDLE_ON) || fast_ok;
    next_st.clk.high_osc_en = high_run;
    next_st.clk.low_osc_en  = low_run;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cur <= ST_RST;
    end
    else
    begin
      cur <= next_st;
    end
  end

  assign rdata   = cur.rdata;
  assign clk_out = cur.clk;
  assign mode    = cur.mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  chk_slow_clock_sel : assert property (
    (!cur.high_speed_select && !(cur.clock_divider_select > SCM_DIV_SUB_MAX)) |=> clk_out.src_sub)
    else $error("substitute clock not selected for codes 0 and 1");

  chk_div_ratio_map : assert property (
    (!cur.high_speed_select && (cur.clock_divider_select > SCM_DIV_SUB_MAX))
    |=> ({1'b0, clk_out.div_log2} == SCM_DIV_TOP - {1'b0, $past(cur.clock_divider_select)}))
    else $error("divide ratio does not match divider code");

  chk_high_undivided : assert property (
    (cur.high_speed_select && high_speed_ready_flag) |=> !clk_out.src_sub && (clk_out.div_log2 == 3'h0))
    else $error("high select did not give undivided high clock");

  // The cycle in which the high flag rises already hands back to the high clock
  chk_fast_wake_run : assert property (
    (fast_ok && !high_speed_ready_flag) |=> clk_out.cpu_run && clk_out.src_sub)
    else $error("fast wake-up did not run on substitute clock");

  chk_deep_low_flag : assert property (
    (cur.mode == SCM_SLEEP_DEEP)[*2] |-> !low_speed_ready_flag)
    else $error("low ready flag high in deep sleep");

  chk_sleep_high_flag : assert property (
    ((cur.mode == SCM_SLEEP_SUB) || (cur.mode == SCM_SLEEP_DEEP) || (cur.mode == SCM_IDLE_OFF))[*2]
    |-> !high_speed_ready_flag)
    else $error("high ready flag high while stopped");

  chk_halt_idle_on : assert property (
    ((cur.mode == SCM_RUN) && halt && cur.idle_select && cur.idle_sysclk_keep)
    |=> (cur.mode == SCM_IDLE_ON) ##1 (!clk_out.cpu_run && clk_out.sysclk_run))
    else $error("halt with idle select did not enter clock-on idle");

  chk_idle_off_stop : assert property (
    ((cur.mode == SCM_RUN) && halt && cur.idle_select && !cur.idle_sysclk_keep)
    |=> (cur.mode == SCM_IDLE_OFF) ##1 (!clk_out.cpu_run && !clk_out.sysclk_run))
    else $error("clock-off idle left CPU or clock running");

  chk_halt_sleep : assert property (
    ((cur.mode == SCM_RUN) && halt && !cur.idle_select)
    |=> ((cur.mode == SCM_SLEEP_SUB) || (cur.mode == SCM_SLEEP_DEEP)))
    else $error("halt without idle select did not enter sleep");

  chk_high_osc_off : assert property (
    ((cur.mode == SCM_RUN) && !wants_high) |=> !clk_out.high_osc_en)
    else $error("high oscillator left on with substitute clock");

  chk_ready_ro : assert property (
    (bus_req.wr && (bus_req.addr == SCM_IDX_MODE) && high_run) |=> ($past(high_speed_ready_flag) ||
    !high_speed_ready_flag || $past(high_tick)))
    else $error("software write changed high ready flag");

  chk_flags_read : assert property (
    (bus_req.rd && (bus_req.addr == SCM_IDX_MODE))
    |=> (rdata[SCM_B_HRDY] == $past(high_speed_ready_flag))
        && (rdata[SCM_B_LRDY] == $past(low_speed_ready_flag)))
    else $error("ready flag read back differs from tracker");

  chk_wake_gate : assert property (
    ((cur.mode == SCM_WAKE) ##1 (cur.mode == SCM_RUN))
    |-> $past(wants_high ? high_speed_ready_flag : low_speed_ready_flag))
    else $error("left wake before the needed oscillator was ready");

  chk_idle_on_wake : assert property (
    ((cur.mode == SCM_IDLE_ON) && wake) |=> (cur.mode == SCM_RUN))
    else $error("wake from clock-on idle did not resume run");

  cov_power_on_run : cover property ($rose(clk_out.cpu_run) && high_speed_ready_flag);
  cov_idle_on_wake : cover property ((cur.mode == SCM_IDLE_ON) ##1 (cur.mode == SCM_RUN));
  cov_fast_wake    : cover property (fast_ok ##1 clk_out.cpu_run);
  cov_deep_wake    : cover property ((cur.mode == SCM_SLEEP_DEEP) ##1 (cur.mode == SCM_WAKE));

endmodule

`default_nettype wire

// File: hdl/scm_osc_ready.sv
// Oscillator ready tracker: counts oscillator ticks after enable.
// Assumes tick is a one-cycle pulse per oscillator cycle, synchronous to clock.

`timescale 1ns/100ps
`default_nettype none

module scm_osc_ready
  import scm_pkg::*;
#(
  parameter int CNT_W = 10
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // Oscillator
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] target,
  // Status
  output var  logic             ready
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             ready;
  } scm_ord_st_t;

  scm_ord_st_t cur;
  scm_ord_st_t next_st;

  always_comb
  begin
    next_st = cur;
    // A stopped oscillator loses its ready status at once
    if (!run)
    begin
      next_st = '0;
    end
    else if (tick && !cur.ready)
    begin
      if (cur.count == target - CNT_W'(1))
      begin
        next_st.ready = 1'b1;
      end
      else
      begin
        next_st.count = cur.count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_st;
    end
  end

  assign ready = cur.ready;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ready_count : assert property (@(posedge clock) disable iff (srst)
    $rose(ready) |-> $past(tick) && $past(run) && ($past(cur.count) == target - CNT_W'(1)))
    else $error("ready rose before the settling count");

  chk_stop_clears : assert property (@(posedge clock) disable iff (srst)
    !run |=> !ready)
    else $error("ready stayed high with oscillator stopped");

endmodule

`default_nettype wire

// File: hdl/scm_pkg.sv
// Package for the system clock and low-power mode control block.
// Assumes one 200 MHz system-side clock; oscillator cycles arrive as tick pulses.

package scm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int           SCM_ADDR_W   = 2;
  localparam logic [1:0]   SCM_IDX_MODE = 2'h0;
  localparam logic [1:0]   SCM_IDX_CTRL = 2'h1;

  // Field positions of the clock mode register
  localparam int           SCM_B_DIV_LO = 5;
  localparam int           SCM_B_FAST   = 4;
  localparam int           SCM_B_LRDY   = 3;
  localparam int           SCM_B_HRDY   = 2;
  localparam int           SCM_B_IDLE   = 1;
  localparam int           SCM_B_HSEL   = 0;
  // Field position of the idle clock keep bit in the control register
  localparam int           SCM_B_KEEP   = 7;

  // Values after reset
  localparam logic [7:0]   SCM_RST_MODE = 8'h03;
  localparam logic [7:0]   SCM_RST_CTRL = 8'h00;

  // Divider codes: 0 and 1 pick the substitute clock, 8 - code is log2 of the ratio
  localparam logic [2:0]   SCM_DIV_SUB_MAX = 3'h1;
  localparam logic [3:0]   SCM_DIV_TOP     = 4'h8;

  // Oscillator settling counts, in cycles of that oscillator
  localparam int           SCM_CNT_W     = 10;
  localparam logic [9:0]   SCM_HXT_CYC   = 10'h200;
  localparam logic [9:0]   SCM_HIGH_SPEED_RC_CYC  = 10'h010;
  localparam logic [9:0]   SCM_LXT_CYC   = 10'h080;
  localparam logic [9:0]   SCM_LOW_SPEED_RC_CYC  = 10'h002;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SCM_RUN        = 3'b000,
    SCM_IDLE_ON    = 3'b001,
    SCM_IDLE_OFF   = 3'b010,
    SCM_SLEEP_SUB  = 3'b011,
    SCM_SLEEP_DEEP = 3'b100,
    SCM_WAKE       = 3'b101
  } scm_mode_t;

  typedef struct packed {
    logic [SCM_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
    logic                  wr;
    logic                  rd;
  } scm_bus_req_t;

  typedef struct packed {
    logic       high_crystal;
    logic       low_crystal;
  } scm_osc_cfg_t;

  typedef struct packed {
    logic       src_sub;
    logic [2:0] div_log2;
    logic       cpu_run;
    logic       sysclk_run;
    logic       high_osc_en;
    logic       low_osc_en;
  } scm_clk_out_t;

endpackage

// File: sim/tb_top.sv
// Self-checking bench for the clock mode control block: register port, halt/wake
// sequencing, oscillator ready flags and clock steering.
// Assumes the block is driven alone; oscillator ticks come from bench tasks.

`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import scm_pkg::*;

  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic         clock;
  logic         srst;
  scm_bus_req_t bus_req;
  logic [7:0]   rdata;
  logic         halt;
  logic         wake;
  scm_osc_cfg_t osc_cfg;
  logic         sub_in_sleep;
  logic         high_tick;
  logic         low_tick;
  scm_clk_out_t clk_out;
  scm_mode_t    mode;
  int           mismatches;
  int           samples_checked;

  scm_clock_mode_control scm_clock_mode_control_i (
    .clock        (clock),
    .srst         (srst),
    .bus_req      (bus_req),
    .rdata        (rdata),
    .halt         (halt),
    .wake         (wake),
    .osc_cfg      (osc_cfg),
    .sub_in_sleep (sub_in_sleep),
    .high_tick    (high_tick),
    .low_tick     (low_tick),
    .clk_out      (clk_out),
    .mode         (mode)
  );

  always #2.5 clock = ~clock;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clock);
    bus_req.wr    <= 1'b0;
  endtask

  // Read data is only valid in the cycle right after the strobe
  task automatic rd_chk(input string name, input logic [1:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clock);
    bus_req.rd   <= 1'b0;
    #1;
    check(name, rdata, exp);
  endtask

  task automatic tick(input logic hi, input int n);
    repeat (n)
    begin
      @(posedge clock);
      if (hi)
        high_tick <= 1'b1;
      else
        low_tick <= 1'b1;
    end
    @(posedge clock);
    high_tick <= 1'b0;
    low_tick  <= 1'b0;
  endtask

  task automatic pulse(input logic is_halt);
    @(posedge clock);
    if (is_halt)
      halt <= 1'b1;
    else
      wake <= 1'b1;
    @(posedge clock);
    halt <= 1'b0;
    wake <= 1'b0;
    #1;
  endtask

  // Bounded wait: a mode that never arrives is reported, not hung on
  task automatic wait_mode(input scm_mode_t m);
    for (int i = 0; i < 40 && mode !== m; i++)
      settle(1);
    check("mode", 8'(mode), 8'(m));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup();
    check("mode after reset", 8'(mode), 8'(SCM_WAKE));
    rd_chk("mode reg reset", SCM_IDX_MODE, 8'h03);
    rd_chk("ctrl reg reset", SCM_IDX_CTRL, 8'h00);
    tick(1'b1, 15);
    rd_chk("high ready at 15", SCM_IDX_MODE, 8'h03);
    tick(1'b1, 1);
    rd_chk("high ready at 16", SCM_IDX_MODE, 8'h07);
    tick(1'b0, 1);
    rd_chk("low ready at 1", SCM_IDX_MODE, 8'h07);
    tick(1'b0, 1);
    rd_chk("low ready at 2", SCM_IDX_MODE, 8'h0F);
    wait_mode(SCM_RUN);
    settle(2);
    check("cpu_run", 8'(clk_out.cpu_run), 8'h01);
  endtask

  task automatic t_regs();
    bus_wr(SCM_IDX_MODE, 8'hF2);
    rd_chk("ready bits kept", SCM_IDX_MODE, 8'hFE);
    settle(1);
    check("rdata after slot", rdata, 8'h00);
    bus_wr(SCM_IDX_CTRL, 8'hFF);
    rd_chk("ctrl reg", SCM_IDX_CTRL, 8'h80);
    rd_chk("unmapped", 2'h2, 8'h00);
  endtask

  task automatic t_div();
    for (int c = 2; c <= 7; c++)
    begin
      bus_wr(SCM_IDX_MODE, {3'(c), 5'b00010});
      settle(3);
      check("src_sub divided", 8'(clk_out.src_sub), 8'h00);
      check("div_log2", 8'(clk_out.div_log2), 8'(8 - c));
    end
    bus_wr(SCM_IDX_MODE, 8'h03);
    settle(3);
    check("div_log2 undivided", 8'(clk_out.div_log2), 8'h00);
    check("src_sub undivided", 8'(clk_out.src_sub), 8'h00);
    for (int c = 1; c >= 0; c--)
    begin
      bus_wr(SCM_IDX_MODE, {3'(c), 5'b00010});
      settle(3);
      check("src_sub substitute", 8'(clk_out.src_sub), 8'h01);
      check("high osc off", 8'(clk_out.high_osc_en), 8'h00);
    end
    bus_wr(SCM_IDX_MODE, 8'h03);
    settle(3);
    tick(1'b1, 16);
    settle(3);
    check("src_sub back to high", 8'(clk_out.src_sub), 8'h00);
  endtask

  task automatic t_idle_keep();
    bus_wr(SCM_IDX_CTRL, 8'h80);
    bus_wr(SCM_IDX_MODE, 8'h03);
    pulse(1'b1);
    check("mode idle on", 8'(mode), 8'(SCM_IDLE_ON));
    settle(2);
    check("cpu_run idle on", 8'(clk_out.cpu_run), 8'h00);
    check("sysclk idle on", 8'(clk_out.sysclk_run), 8'h01);
    pulse(1'b0);
    wait_mode(SCM_RUN);
  endtask

  task automatic t_idle_off();
    @(posedge clock);
    osc_cfg.high_crystal <= 1'b1;
    bus_wr(SCM_IDX_CTRL, 8'h00);
    pulse(1'b1);
    check("mode idle off", 8'(mode), 8'(SCM_IDLE_OFF));
    settle(2);
    check("cpu_run idle off", 8'(clk_out.cpu_run), 8'h00);
    check("sysclk idle off", 8'(clk_out.sysclk_run), 8'h00);
    settle(3);
    rd_chk("high ready in idle", SCM_IDX_MODE, 8'h0B);
    pulse(1'b0);
    check("mode wake", 8'(mode), 8'(SCM_WAKE));
    settle(3);
    tick(1'b1, 511);
    rd_chk("high ready at 511", SCM_IDX_MODE, 8'h0B);
    tick(1'b1, 1);
    rd_chk("high ready at 512", SCM_IDX_MODE, 8'h0F);
    wait_mode(SCM_RUN);
  endtask

  task automatic t_deep();
    @(posedge clock);
    osc_cfg.low_crystal <= 1'b1;
    sub_in_sleep        <= 1'b0;
    bus_wr(SCM_IDX_MODE, 8'h01);
    pulse(1'b1);
    check("mode deep", 8'(mode), 8'(SCM_SLEEP_DEEP));
    settle(2);
    check("low osc off", 8'(clk_out.low_osc_en), 8'h00);
    settle(3);
    rd_chk("ready flags in deep", SCM_IDX_MODE, 8'h01);
    pulse(1'b0);
    settle(3);
    tick(1'b0, 127);
    rd_chk("low ready at 127", SCM_IDX_MODE, 8'h01);
    tick(1'b0, 1);
    rd_chk("low ready at 128", SCM_IDX_MODE, 8'h09);
    tick(1'b1, 512);
    wait_mode(SCM_RUN);
  endtask

  task automatic t_fast();
    @(posedge clock);
    sub_in_sleep <= 1'b1;
    bus_wr(SCM_IDX_MODE, 8'h11);
    pulse(1'b1);
    check("mode sleep sub", 8'(mode), 8'(SCM_SLEEP_SUB));
    pulse(1'b0);
    settle(3);
    check("mode fast wake", 8'(mode), 8'(SCM_WAKE));
    check("cpu_run fast wake", 8'(clk_out.cpu_run), 8'h01);
    check("src_sub fast wake", 8'(clk_out.src_sub), 8'h01);
    tick(1'b1, 512);
    wait_mode(SCM_RUN);
    settle(2);
    check("src_sub after settle", 8'(clk_out.src_sub), 8'h00);
    pulse(1'b0);
    check("wake in run ignored", 8'(mode), 8'(SCM_RUN));
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clock           = 1'b0;
    srst            = 1'b1;
    bus_req         = '0;
    halt            = 1'b0;
    wake            = 1'b0;
    osc_cfg         = '0;
    sub_in_sleep    = 1'b1;
    high_tick       = 1'b0;
    low_tick        = 1'b0;
    mismatches      = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    settle(1);
    t_powerup();
    t_regs();
    t_div();
    t_idle_keep();
    t_idle_off();
    t_deep();
    t_fast();
    summarize();
  end

  // Whole run needs a few thousand cycles; this span leaves ample margin
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    summarize();
  end

endmodule

`default_nettype wire
